// [inc/ipb_consts.vh]
// Constants for the instruction prefetch queue: memory map edges, depths, widths.
// Assumes a 16-bit instruction word and a 22-bit word address space.
`ifndef IPB_CONSTS_VH
`define IPB_CONSTS_VH

`define IPB_ADDR_W        22
`define IPB_DATA_W        16
`define IPB_QUEUE_DEPTH   16
`define IPB_PTR_W         4
`define IPB_CNT_W         5
`define IPB_RAM_LIMIT     5'h08
`define IPB_FLASH_LIMIT   5'h10
// Lower small RAM block followed by the upper one, which has nothing after it
`define IPB_LSRB_BASE     22'h000000
`define IPB_LSRB_END      22'h0003ff
`define IPB_USRB_BASE     22'h000400
`define IPB_USRB_END      22'h0007ff
// Shared RAM block three
`define IPB_SRB3_BASE     22'h00c000
`define IPB_SRB3_END      22'h00c7ff
// Flash array
`define IPB_FLASH_BASE    22'h080000
`define IPB_FLASH_END     22'h08ffff
// Word returned for a fetch that hits no memory (an illegal opcode)
`define IPB_INVALID_OP    16'h0000
// State codes, one-hot
`define IPB_ST_IDLE       2'b01
`define IPB_ST_WAIT       2'b10

`endif

// [core/ipb_queue_mem.v]
// Storage array of the prefetch queue: one write port, one registered read port.
// Assumes the controller never writes and reads the same slot in conflict.
`timescale 1ns/1ns
`include "ipb_consts.vh"

module ipb_queue_mem (
   core_clk,
   clk_en,
   wr_en,
   wr_addr,
   wr_data,
   wr_err,
   rd_en,
   rd_addr,
   rd_data,
   rd_err
);
   input  wire                      core_clk;
   input  wire                      clk_en;
   input  wire                      wr_en;
   input  wire [`IPB_PTR_W-1:0]     wr_addr;
   input  wire [`IPB_DATA_W-1:0]    wr_data;
   input  wire                      wr_err;
   input  wire                      rd_en;
   input  wire [`IPB_PTR_W-1:0]     rd_addr;
   output reg  [`IPB_DATA_W-1:0]    rd_data;
   output reg                       rd_err;

   // ==================================================================
   // Array
   // No reset on the array; entries are only read once marked valid
   reg [`IPB_DATA_W-1:0] mem_word [0:`IPB_QUEUE_DEPTH-1];
   reg                   mem_err  [0:`IPB_QUEUE_DEPTH-1];

   // Write and registered read
   always @(posedge core_clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem_word[wr_addr] <= wr_data;
            mem_err[wr_addr]  <= wr_err;
         end
         // Read only on a load, so the presented word stands until taken
         if (rd_en) begin
            rd_data <= mem_word[rd_addr];
            rd_err  <= mem_err[rd_addr];
         end
      end
   end
endmodule

// [core/ipb_prefetch.v]
// Instruction prefetch queue between instruction memory and the execute pipeline.
// Assumes a memory port with one outstanding read and a one-cycle-or-later answer.
// Overview of operation
// - Fetch words ahead of execution; past valid memory an invalid opcode is queued.
// - From RAM blocks the queue runs at most 8 words ahead.
// - From flash the queue runs at most 16 words ahead.
// - A flash fetch past the last flash word flags an uncorrectable ECC error.
// - Crossing between adjacent valid blocks fetches normally, without error.
`timescale 1ns/1ns
`include "ipb_consts.vh"

module ipb_prefetch (
   core_clk,
   rst_n,
   clk_en,
   redirect,
   redirect_addr,
   mem_req,
   mem_addr,
   mem_ack,
   mem_rdata,
   flash_ecc_uncorr,
   instr_valid,
   instr_ready,
   instr_word,
   instr_addr,
   instr_invalid,
   instr_ecc_err,
   ecc_uncorr_event,
   queue_level
);
   input  wire                      core_clk;
   input  wire                      rst_n;
   input  wire                      clk_en;
   input  wire                      redirect;
   input  wire [`IPB_ADDR_W-1:0]    redirect_addr;
   output wire                      mem_req;
   output reg  [`IPB_ADDR_W-1:0]    mem_addr;
   input  wire                      mem_ack;
   input  wire [`IPB_DATA_W-1:0]    mem_rdata;
   input  wire                      flash_ecc_uncorr;
   output wire                      instr_valid;
   input  wire                      instr_ready;
   output wire [`IPB_DATA_W-1:0]    instr_word;
   output reg  [`IPB_ADDR_W-1:0]    instr_addr;
   output wire                      instr_invalid;
   output wire                      instr_ecc_err;
   output reg                       ecc_uncorr_event;
   output wire [`IPB_CNT_W-1:0]     queue_level;

   // ==================================================================
   // Address classification
   // Decode used for both the fetch address and the limit choice
   function [2:0] ipb_region;
      input [`IPB_ADDR_W-1:0] a;
      begin
         if (a <= `IPB_USRB_END)
            ipb_region = 3'h1;                      // Both small blocks are contiguous
         else if (a >= `IPB_SRB3_BASE && a <= `IPB_SRB3_END)
            ipb_region = 3'h1;
         else if (a >= `IPB_FLASH_BASE && a <= `IPB_FLASH_END)
            ipb_region = 3'h2;
         else if (a >= `IPB_FLASH_BASE)
            ipb_region = 3'h4;                      // Past flash: answered by flash interface
         else
            ipb_region = 3'h0;                      // Hole: no memory answers
      end
   endfunction

   // ==================================================================
   // State
   reg  [1:0]              state_reg;
   reg  [1:0]              state_next;
   reg  [`IPB_ADDR_W-1:0]  fetch_addr_reg;          // Next word to request
   reg  [`IPB_PTR_W-1:0]   wr_ptr_reg;
   reg  [`IPB_PTR_W-1:0]   rd_ptr_reg;
   reg  [`IPB_CNT_W-1:0]   count_reg;
   reg                     flash_mode_reg;          // Queue is fed from flash
   reg                     drop_reg;                // Discard answer of a flushed read
   reg                     out_valid_reg;
   reg                     hole_reg;                // Current read hit no memory
   reg                     past_flash_reg;          // Current read ran past flash end
   reg  [`IPB_ADDR_W-1:0]  req_addr_reg;
   reg  [`IPB_ADDR_W-1:0]  addr_q [0:`IPB_QUEUE_DEPTH-1];

   wire [2:0]              fetch_rgn  = ipb_region(fetch_addr_reg);
   wire [`IPB_CNT_W-1:0]   depth_lim  = flash_mode_reg ? `IPB_FLASH_LIMIT : `IPB_RAM_LIMIT;
   // Entries in flight count against the limit so the queue never overshoots
   wire [`IPB_CNT_W-1:0]   inflight   = (state_reg == `IPB_ST_WAIT && !drop_reg) ? 5'h01 : 5'h00;
   wire                    room       = (count_reg + inflight) < depth_lim;
   wire                    issue      = (state_reg == `IPB_ST_IDLE) && room && !redirect;
   wire                    hole_now   = (fetch_rgn == 3'h0);
   // A hole answers at once with an invalid opcode; real memory answers on ack
   wire                    done       = (state_reg == `IPB_ST_WAIT) && (hole_reg || mem_ack);
   wire                    push       = done && !drop_reg && !redirect;
   wire                    nonempty   = (count_reg != 5'h00);
   wire                    pop        = out_valid_reg && instr_ready && !redirect;
   wire                    load_out   = nonempty && (!out_valid_reg || pop);
   wire [`IPB_DATA_W-1:0]  wr_word    = hole_reg ? `IPB_INVALID_OP : mem_rdata;
   wire                    wr_err     = past_flash_reg || (flash_mode_reg && flash_ecc_uncorr);
   wire                    mem_err_q;

   // Request stands until answered, even for a flushed read, or memory never acks
   assign mem_req      = (state_reg == `IPB_ST_WAIT) && !hole_reg;
   assign instr_valid  = out_valid_reg;
   assign instr_ecc_err = out_valid_reg && mem_err_q;
   assign queue_level  = count_reg;

   // ==================================================================
   // Queue storage
   ipb_queue_mem u_mem (
      .core_clk (core_clk),
      .clk_en   (clk_en),
      .wr_en    (push),
      .wr_addr  (wr_ptr_reg),
      .wr_data  (wr_word),
      .wr_err   (wr_err),
      .rd_en    (load_out && !redirect),
      .rd_addr  (rd_ptr_reg),
      .rd_data  (instr_word),
      .rd_err   (mem_err_q)
   );

   // Opcode is invalid when it came from a hole or was flagged by flash ECC
   assign instr_invalid = out_valid_reg && (mem_err_q || (instr_word == `IPB_INVALID_OP));

   // ==================================================================
   // Fetch state machine
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `IPB_ST_IDLE: begin
            if (issue)
               state_next = `IPB_ST_WAIT;
         end
         `IPB_ST_WAIT: begin
            if (done)
               state_next = `IPB_ST_IDLE;
         end
         default: state_next = `IPB_ST_IDLE;
      endcase
   end

   // Sequencing, pointers and flush
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg        <= `IPB_ST_IDLE;
         fetch_addr_reg   <= 22'h000000;
         req_addr_reg     <= 22'h000000;
         mem_addr         <= 22'h000000;
         wr_ptr_reg       <= 4'h0;
         rd_ptr_reg       <= 4'h0;
         count_reg        <= 5'h00;
         flash_mode_reg   <= 1'b0;
         drop_reg         <= 1'b0;
         out_valid_reg    <= 1'b0;
         hole_reg         <= 1'b0;
         past_flash_reg   <= 1'b0;
         instr_addr       <= 22'h000000;
         ecc_uncorr_event <= 1'b0;
      end else if (clk_en) begin
         state_reg        <= state_next;
         ecc_uncorr_event <= push && wr_err;
         if (redirect) begin
            // Flush: invalid words fetched ahead can never reach execute
            fetch_addr_reg <= redirect_addr;
            wr_ptr_reg     <= 4'h0;
            rd_ptr_reg     <= 4'h0;
            count_reg      <= 5'h00;
            out_valid_reg  <= 1'b0;
            flash_mode_reg <= (ipb_region(redirect_addr) != 3'h1);
            // A read still outstanding must finish but its word is thrown away
            // An answer in this very cycle ends any earlier drop as well
            drop_reg <= (state_reg == `IPB_ST_WAIT) && !done;
         end else begin
            if (issue) begin
               mem_addr       <= fetch_addr_reg;
               req_addr_reg   <= fetch_addr_reg;
               hole_reg       <= hole_now;
               past_flash_reg <= (fetch_rgn == 3'h4);
               fetch_addr_reg <= fetch_addr_reg + 22'h000001;
            end
            if (done)
               drop_reg <= 1'b0;
            if (push) begin
               addr_q[wr_ptr_reg] <= req_addr_reg;
               wr_ptr_reg         <= wr_ptr_reg + 4'h1;
            end
            if (load_out) begin
               instr_addr <= addr_q[rd_ptr_reg];
               rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
            if (load_out)
               out_valid_reg <= 1'b1;
            else if (pop)
               out_valid_reg <= 1'b0;
            count_reg <= count_reg + (push ? 5'h01 : 5'h00) - (load_out ? 5'h01 : 5'h00);
         end
      end
   end
endmodule

// [verif/ipb_prefetch_sva.sv]
// Checker for the prefetch queue: depth limits, flush, error flags, read order.
// Assumes it is bound to ipb_prefetch and watches only its ports.
`timescale 1ns/1ns
`include "ipb_consts.vh"
module ipb_prefetch_sva (
   input wire                   core_clk,
   input wire                   rst_n,
   input wire                   redirect,
   input wire [`IPB_ADDR_W-1:0] redirect_addr,
   input wire                   mem_req,
   input wire [`IPB_ADDR_W-1:0] mem_addr,
   input wire                   mem_ack,
   input wire                   flash_ecc_uncorr,
   input wire                   instr_valid,
   input wire                   instr_ready,
   input wire [`IPB_ADDR_W-1:0] instr_addr,
   input wire [`IPB_DATA_W-1:0] instr_word,
   input wire                   ecc_uncorr_event,
   input wire [`IPB_CNT_W-1:0]  queue_level
);
   reg                   fl_reg;
   reg [`IPB_ADDR_W-1:0] exp_reg;
   reg                   drain_reg;             // Read outstanding at a flush; answer discarded
   // ==========================================================
   // Mode and next read address, tracked from redirects and answers
   always @(posedge core_clk or negedge rst_n)
      if (!rst_n) begin
         fl_reg <= 1'b0;
         exp_reg <= 22'h0;
         drain_reg <= 1'b0;
      end else if (redirect) begin
         fl_reg <= !(redirect_addr <= `IPB_USRB_END ||
            (redirect_addr >= `IPB_SRB3_BASE && redirect_addr <= `IPB_SRB3_END));
         exp_reg <= redirect_addr;
         drain_reg <= mem_req && !mem_ack;
      end else if (mem_req && mem_ack) begin
         if (!drain_reg)
            exp_reg <= mem_addr + 22'h1;
         drain_reg <= 1'b0;
      end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_ram_depth: assert property (!fl_reg && !redirect |-> queue_level <= 5'h08)
      else $error("queue ran past the RAM depth");
   a_flash_depth: assert property (queue_level <= 5'h10)
      else $error("queue ran past the flash depth");
   a_ecc_flag: assert property (mem_req && mem_ack && flash_ecc_uncorr && !redirect && !drain_reg
      |-> ##[1:2] ecc_uncorr_event) else $error("uncorrectable word gave no event");
   a_flush_all: assert property (redirect |=> !instr_valid && queue_level == 5'h00)
      else $error("redirect left words behind");
   a_req_hold: assert property (mem_req && !mem_ack && !redirect |=> mem_req && $stable(mem_addr))
      else $error("read dropped before its answer");
   a_out_hold: assert property (instr_valid && !instr_ready && !redirect
      |=> instr_valid && $stable(instr_addr) && $stable(instr_word))
      else $error("presented word changed");
   a_next_word: assert property ($rose(mem_req) && !redirect |-> mem_addr == exp_reg)
      else $error("read address out of sequence");
   cover property (queue_level == 5'h10);
   cover property (ecc_uncorr_event);
   cover property (redirect && mem_req);
endmodule
bind ipb_prefetch ipb_prefetch_sva ipb_prefetch_sva_inst (.core_clk, .rst_n, .redirect,
   .redirect_addr, .mem_req, .mem_addr, .mem_ack, .flash_ecc_uncorr, .instr_valid,
   .instr_ready, .instr_addr, .instr_word, .ecc_uncorr_event, .queue_level);

// [verif/ipb_mem_model.sv]
// Memory model: RAM and flash behind one read port, answering after a set lag.
// Assumes one read at a time, held by the requester until answered.
`timescale 1ns/1ns
`include "ipb_consts.vh"
module ipb_mem_model (
   input  wire                   core_clk,
   input  wire                   rst_n,
   input  wire [1:0]             lag,
   input  wire                   mem_req,
   input  wire [`IPB_ADDR_W-1:0] mem_addr,
   output wire                   mem_ack,
   output wire [`IPB_DATA_W-1:0] mem_rdata,
   output wire                   flash_ecc_uncorr
);
   reg [1:0]  wait_reg;
   reg [15:0] junk_reg;
   // ==========================================================
   // Answer only while the read is held, so a dropped read gets none
   assign mem_ack = mem_req && wait_reg >= lag;
   assign mem_rdata = mem_ack ? mem_addr[15:0] ^ 16'ha5a5 : junk_reg;
   assign flash_ecc_uncorr = mem_ack && mem_addr > `IPB_FLASH_END;
   // Idle data toggles so a stale word never looks valid
   always @(posedge core_clk or negedge rst_n)
      if (!rst_n) begin
         wait_reg <= 2'h0;
         junk_reg <= 16'h0;
      end else begin
         wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
         junk_reg <= ~mem_rdata;
      end
endmodule

// [verif/test_ipb_prefetch.sv]
// Testbench for the prefetch queue: depths, block crossing, hole, flash end, flush.
// Assumes the memory model answers each address with address xor a5a5.
`timescale 1ns/1ns
`include "ipb_consts.vh"
module test_ipb_prefetch;
   reg                    core_clk = 1'b0;
   reg                    rst_n = 1'b0;
   reg                    redirect = 1'b0;
   reg  [`IPB_ADDR_W-1:0] redirect_addr = 22'h0;
   reg                    instr_ready = 1'b0;
   reg  [1:0]             lag = 2'h0;
   wire                   mem_req, mem_ack, flash_ecc_uncorr, instr_valid;
   wire                   instr_invalid, instr_ecc_err, ecc_uncorr_event;
   wire [`IPB_ADDR_W-1:0] mem_addr, instr_addr;
   wire [`IPB_DATA_W-1:0] mem_rdata, instr_word;
   wire [`IPB_CNT_W-1:0]  queue_level;
   integer                error_cnt = 0;
   integer                checks_done = 0;
   integer                ev_cnt = 0;
   integer                e0;
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (ecc_uncorr_event === 1'b1)
         ev_cnt <= ev_cnt + 1;
   ipb_prefetch ipb_prefetch_inst (.core_clk, .rst_n, .clk_en(1'b1), .redirect,
      .redirect_addr, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .flash_ecc_uncorr,
      .instr_valid, .instr_ready, .instr_word, .instr_addr, .instr_invalid,
      .instr_ecc_err, .ecc_uncorr_event, .queue_level);
   ipb_mem_model ipb_mem_model_inst (.core_clk, .rst_n, .lag, .mem_req, .mem_addr,
      .mem_ack, .mem_rdata, .flash_ecc_uncorr);
   // ==========================================================
   task report_and_stop;
      begin
         $display("errors %0d checks %0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [21:0] seen, input [21:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task go(input [21:0] a);
      begin
         @(posedge core_clk);
         redirect <= 1'b1;
         redirect_addr <= a;
         @(posedge core_clk);
         redirect <= 1'b0;
      end
   endtask
   // Judge the presented word (kind 0 good, 1 hole, 2 ECC), then accept it
   task take(input [21:0] a, input [1:0] k);
      integer n;
      begin
         n = 0;
         @(negedge core_clk);
         while (instr_valid !== 1'b1 && n < 60) begin
            n = n + 1;
            @(negedge core_clk);
         end
         chk(instr_addr, a);
         chk(instr_invalid, k != 2'h0);
         chk(instr_ecc_err, k == 2'h2);
         if (k != 2'h2)
            chk(instr_word, k == 2'h0 ? a[15:0] ^ 16'ha5a5 : 16'h0);
         @(posedge core_clk);
         instr_ready <= 1'b1;
         @(posedge core_clk);
         instr_ready <= 1'b0;
      end
   endtask
   // Slow memory; lower block runs on into the upper one
   task t_cross;
      integer i;
      begin
         lag <= 2'h2;
         go(22'h0003fc); // Code fills the lower block's end
         repeat (60) @(posedge core_clk);
         chk(queue_level, 22'h8);
         for (i = 0; i < 8; i = i + 1)
            take(22'h0003fc + i, 2'h0);
         lag <= 2'h0;
      end
   endtask
   // Nothing follows the upper block, so prefetch meets a hole
   task t_hole;
      integer i;
      begin
         go(22'h0007f4); // Last code word sits at 0x7ff
         for (i = 0; i < 16; i = i + 1)
            take(22'h0007f4 + i, {1'b0, i > 11});
      end
   endtask
   // Flash depth, then nine words fetched past the flash end
   task t_flash;
      integer i;
      begin
         go(22'h080000);
         repeat (60) @(posedge core_clk);
         chk(queue_level, 22'h10);
         e0 = ev_cnt;
         go(22'h08fff8);
         repeat (60) @(posedge core_clk);
         chk(ev_cnt - e0, 22'h9);
         for (i = 0; i < 10; i = i + 1)
            take(22'h08fff8 + i, {i > 7, 1'b0});
      end
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_cross;
      t_hole;
      t_flash;
      report_and_stop;
   end
   // Watchdog: the sequence needs about 280 cycles, this allows 10000
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
endmodule
